// File: hw/gnpa_pkg.sv
// Constants and types of the gigabit next page add-on.
// Assumes a 5-bit register address and 16-bit management words.
package gnpa_pkg;

    // ==========================================================
    // Register addresses
    localparam logic [4:0]  GNPA_ADDR_BASE   = 5'h04;
    localparam logic [4:0]  GNPA_ADDR_TXNP   = 5'h07;
    localparam logic [4:0]  GNPA_ADDR_RXNP   = 5'h08;
    localparam logic [4:0]  GNPA_ADDR_GIGCTL = 5'h09;
    localparam logic [4:0]  GNPA_ADDR_GIGST  = 5'h0A;
    localparam logic [4:0]  GNPA_ADDR_CTRL   = 5'h10;
    localparam logic [4:0]  GNPA_ADDR_STAT   = 5'h11;

    // ==========================================================
    // Field positions
    localparam int unsigned GNPA_BIT_NP      = 15;
    localparam int unsigned GNPA_BIT_MP      = 13;
    localparam int unsigned GNPA_BIT_HD      = 8;
    localparam int unsigned GNPA_BIT_FD      = 9;
    localparam int unsigned GNPA_BIT_PORT    = 10;
    localparam int unsigned GNPA_BIT_MVAL    = 11;
    localparam int unsigned GNPA_BIT_MEN     = 12;
    localparam int unsigned GNPA_BIT_FAULT   = 15;
    localparam int unsigned GNPA_BIT_MASTER  = 14;
    localparam int unsigned GNPA_BIT_SWMODE  = 0;

    // ==========================================================
    // Reset values and codes
    localparam logic [15:0] GNPA_RST_BASE    = 16'h0001;
    localparam logic [15:0] GNPA_RST_GIGCTL  = 16'h0300;
    localparam logic [15:0] GNPA_RST_ZERO    = 16'h0000;
    localparam logic [10:0] GNPA_MSG_CODE    = 11'h008;
    localparam logic [2:0]  GNPA_CNT_MAX     = 3'h7;
    localparam logic [1:0]  GNPA_RX_MSG      = 2'h0;
    localparam logic [1:0]  GNPA_RX_UP1      = 2'h1;
    localparam logic [1:0]  GNPA_RX_UP2      = 2'h2;
    localparam logic [1:0]  GNPA_RX_EXTRA    = 2'h3;

    typedef enum logic [2:0] {
        GNPA_TX_BASE,
        GNPA_TX_MSG,
        GNPA_TX_UP1,
        GNPA_TX_UP2,
        GNPA_TX_SOFT,
        GNPA_TX_DONE
    } gnpa_tx_state_t;

endpackage

// File: hw/gnpa_resolve.sv
// Master-slave resolution with the failed-attempt counter.
// Assumes resolve is a one-cycle pulse on sys_clk.
`timescale 1ns/1ps
module gnpa_resolve (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        ce,
    // Control
    input  wire logic        resolve,
    // Local and partner configuration
    input  wire logic [4:0]  local_cfg,
    input  wire logic [10:0] local_seed,
    input  wire logic [4:0]  partner_cfg,
    input  wire logic [10:0] partner_seed,
    // Results
    output logic             master,
    output logic             fault,
    output logic [2:0]       count
);
    import gnpa_pkg::*;

    typedef struct packed {
        logic       master;
        logic       fault;
        logic [2:0] count;
    } gnpa_res_state_t;

    gnpa_res_state_t res_reg;
    gnpa_res_state_t res_next;

    localparam int unsigned MEN  = GNPA_BIT_MEN - GNPA_BIT_HD;
    localparam int unsigned MVAL = GNPA_BIT_MVAL - GNPA_BIT_HD;
    localparam int unsigned PORT = GNPA_BIT_PORT - GNPA_BIT_HD;

    logic lm, pm;
    assign lm = local_cfg[MEN];
    assign pm = partner_cfg[MEN];

    // ==========================================================
    // Resolution
    always_comb begin
        res_next = res_reg;
        if (resolve) begin
            res_next.fault = 1'b0;
            if (lm && pm) begin
                res_next.master = local_cfg[MVAL];
                res_next.fault  = (local_cfg[MVAL] == partner_cfg[MVAL]);  // [RL4]
            end else if (lm) begin
                res_next.master = local_cfg[MVAL];
            end else if (pm) begin
                res_next.master = ~partner_cfg[MVAL];
            end else if (local_cfg[PORT] != partner_cfg[PORT]) begin
                res_next.master = local_cfg[PORT];
            end else if (local_seed != partner_seed) begin
                res_next.master = (local_seed > partner_seed);
                res_next.count  = 3'h0;
            end else begin
                // Saturate rather than wrap, so the fault stays visible
                if (res_reg.count != GNPA_CNT_MAX) begin                    // [RL3]
                    res_next.count = res_reg.count + 3'h1;                  // [RL2]
                end
                res_next.fault = (res_reg.count >= GNPA_CNT_MAX - 3'h1);    // [RL4]
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            res_reg <= '0;
        end else if (ce) begin
            res_reg <= res_next;
        end
    end

    assign master = res_reg.master;
    assign fault  = res_reg.fault;
    assign count  = res_reg.count;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    cnt_bound_a: assert property (count <= GNPA_CNT_MAX)  // [RL2]
        else $error("failed resolution counter above maximum");
    cnt_sat_a: assert property (                          // [RL3]
        ce && resolve && !lm && !pm && local_cfg[PORT] == partner_cfg[PORT]
        && local_seed == partner_seed && count == GNPA_CNT_MAX |=> count == GNPA_CNT_MAX)
        else $error("failed resolution counter wrapped");
    manual_fault_a: assert property (                     // [RL4]
        ce && resolve && lm && pm && local_cfg[MVAL] == partner_cfg[MVAL] |=> fault)
        else $error("manual role conflict not reported");

endmodule

// File: hw/gnpa_top.sv
// Gigabit next page add-on between management registers and the
// base auto-negotiation arbitration engine.
// Assumes the engine runs on sys_clk and gives one-cycle pulses.
//
// Operation
// RL1: Three gigabit configuration pages go out before any user pages.
// RL2: Failed master-slave resolution counter never exceeds seven.
// RL3: Failed resolution counter saturates instead of wrapping.
// RL4: Role resolution fault indication reports the resolution outcome.
// RL5: Gigabit advert wanted is true when bit 9.8 or 9.9 is set.
// RL6: Local gigabit ability word mirrors and reports register 9.
// RL7: Partner gigabit ability word formed from received pages into register 10.
// RL8: Every received next page is written bit for bit into register 8.
// RL9: Eleven-bit partner seed store feeds master-slave resolution.
// RL10: Base page word reaches the engine through the transmit machine.
// RL11: Register 7 page and loaded flag reach engine through transmit machine.
// RL12: Add-on supplies optional answers to engine's wait-for-next-page state.
// RL13: Without extra pages, gigabit pages are sent with no software help.
// RL14: Software loads three dummy pages; device substitutes gigabit pages.
// RL15: Software ends its exchange by loading its own null page.
// RL16: Page-loaded flag clears as in base negotiation, when engine takes page.
// RL17: Without software, gigabit pages are received and stored automatically.
// RL18: Extra received pages still land in register 8, newest overwriting.
// RL19: With software taking part, gigabit contents still stored internally.
// RL20: Software should discard the first three received pages.
// RL21: Master-slave resolved on entry to link-good-check after exchange.
`timescale 1ns/1ps
module gnpa_top (
    // Clock, reset, enable
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        ce,
    // Register port
    input  wire logic [4:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // Arbitration engine side
    input  wire logic        eng_restart,
    input  wire logic        eng_tx_ack,
    input  wire logic        eng_rx_valid,
    input  wire logic [15:0] eng_rx_page,
    input  wire logic        eng_good_check,
    input  wire logic [10:0] local_seed,
    output logic      [15:0] advertised_ability_word,
    output logic      [15:0] page_to_transmit,
    output logic             page_loaded_to_engine,
    // Status
    output logic             gigabit_advert_wanted,
    output logic             role_master,
    output logic             role_fault,
    output logic      [2:0]  failed_resolution_counter
);
    import gnpa_pkg::*;

    typedef struct packed {
        logic [15:0]    base_page_intermediate;
        logic [15:0]    tx_page_intermediate;
        logic           sw_loaded;
        logic [15:0]    local_gigabit_ability_word;
        logic [15:0]    rx_page_word;
        logic [15:0]    partner_gigabit_ability_word;
        logic [10:0]    partner_seed;
        logic           sw_mode;
        logic [1:0]     rx_idx;
        gnpa_tx_state_t tx_state;
        logic [15:0]    adv_out;
        logic [15:0]    np_out;
        logic           np_loaded;
        logic           gig_wanted;
        logic           good_check_d;
        logic           master_out;
        logic           fault_out;
        logic [2:0]     cnt_out;
        logic [15:0]    rdata;
    } gnpa_state_t;

    gnpa_state_t st_reg;
    gnpa_state_t st_next;

    logic       res_master;
    logic       res_fault;
    logic [2:0] res_count;

    // ==========================================================
    // Helpers
    function automatic logic [15:0] gnpa_page(input logic np, input logic mp,
                                              input logic [10:0] data);
        logic [15:0] w;
        w                 = GNPA_RST_ZERO;
        w[GNPA_BIT_NP]    = np;
        w[GNPA_BIT_MP]    = mp;
        w[10:0]           = data;
        return w;
    endfunction

    function automatic logic gnpa_gig(input logic [15:0] ctl);
        return ctl[GNPA_BIT_FD] | ctl[GNPA_BIT_HD];
    endfunction

    logic gig_now;
    assign gig_now = gnpa_gig(st_reg.local_gigabit_ability_word);  // [RL5]

    // ==========================================================
    // Next state
    always_comb begin
        st_next           = st_reg;
        st_next.rdata     = GNPA_RST_ZERO;
        st_next.gig_wanted = gig_now;                               // [RL5]
        st_next.good_check_d = eng_good_check;
        st_next.master_out = res_master;
        st_next.fault_out  = res_fault;
        st_next.cnt_out    = res_count;
        st_next.partner_gigabit_ability_word[GNPA_BIT_FAULT]  = res_fault;  // [RL7]
        st_next.partner_gigabit_ability_word[GNPA_BIT_MASTER] = res_master;

        // Transmit side: all engine-facing words pass through here
        case (st_reg.tx_state)
            GNPA_TX_BASE: begin
                st_next.np_loaded = 1'b0;
                st_next.adv_out   = st_reg.base_page_intermediate;  // [RL10]
                st_next.adv_out[GNPA_BIT_NP] = gig_now | st_reg.sw_mode
                                             | st_reg.base_page_intermediate[GNPA_BIT_NP];
                if (eng_tx_ack) begin
                    if (gig_now) begin
                        st_next.tx_state = GNPA_TX_MSG;             // [RL1]
                    end else if (st_reg.sw_mode) begin
                        st_next.tx_state = GNPA_TX_SOFT;
                    end else begin
                        st_next.tx_state = GNPA_TX_DONE;
                    end
                end
            end
            GNPA_TX_MSG, GNPA_TX_UP1, GNPA_TX_UP2: begin
                // Software pages only pace the exchange; their contents are replaced
                st_next.np_loaded = st_reg.sw_mode ? st_reg.sw_loaded : 1'b1;  // [RL13] [RL14]
                if (st_reg.tx_state == GNPA_TX_MSG) begin
                    st_next.np_out = gnpa_page(1'b1, 1'b1, GNPA_MSG_CODE);
                end else if (st_reg.tx_state == GNPA_TX_UP1) begin
                    st_next.np_out = gnpa_page(1'b1, 1'b0,
                        {6'h00, st_reg.local_gigabit_ability_word[GNPA_BIT_MEN:GNPA_BIT_HD]});
                end else begin
                    // Last gigabit page ends the exchange unless software follows
                    st_next.np_out = gnpa_page(st_reg.sw_mode, 1'b0, local_seed);
                end
                if (eng_tx_ack && st_reg.np_loaded) begin           // [RL12]
                    st_next.sw_loaded = 1'b0;                       // [RL16]
                    if (st_reg.tx_state == GNPA_TX_MSG) begin
                        st_next.tx_state = GNPA_TX_UP1;
                    end else if (st_reg.tx_state == GNPA_TX_UP1) begin
                        st_next.tx_state = GNPA_TX_UP2;
                    end else begin
                        st_next.tx_state = st_reg.sw_mode ? GNPA_TX_SOFT : GNPA_TX_DONE;
                    end
                end
            end
            GNPA_TX_SOFT: begin
                st_next.np_out    = st_reg.tx_page_intermediate;    // [RL11]
                st_next.np_loaded = st_reg.sw_loaded;               // [RL11]
                if (eng_tx_ack && st_reg.np_loaded) begin
                    st_next.sw_loaded = 1'b0;                       // [RL16]
                    if (!st_reg.np_out[GNPA_BIT_NP]) begin
                        st_next.tx_state = GNPA_TX_DONE;            // [RL15]
                    end
                end
            end
            GNPA_TX_DONE: begin
                st_next.np_loaded = 1'b0;
            end
            default: begin
                st_next.tx_state = GNPA_TX_DONE;
            end
        endcase

        // Receive side
        if (eng_rx_valid) begin
            st_next.rx_page_word = eng_rx_page;                     // [RL8] [RL18]
            if (st_reg.rx_idx != GNPA_RX_EXTRA) begin
                st_next.rx_idx = st_reg.rx_idx + 2'h1;
            end
            if (gig_now && st_reg.rx_idx == GNPA_RX_UP1) begin     // [RL17] [RL19]
                st_next.partner_gigabit_ability_word[GNPA_BIT_MEN:GNPA_BIT_HD] =
                    eng_rx_page[4:0];                               // [RL7]
            end
            if (gig_now && st_reg.rx_idx == GNPA_RX_UP2) begin
                st_next.partner_seed = eng_rx_page[10:0];           // [RL9]
            end
        end

        if (eng_restart) begin
            st_next.tx_state  = GNPA_TX_BASE;
            st_next.rx_idx    = GNPA_RX_MSG;
            st_next.np_loaded = 1'b0;
        end

        // Register writes; a load wins over the taken-clear in the same cycle
        if (reg_wr) begin
            case (reg_addr)
                GNPA_ADDR_BASE: st_next.base_page_intermediate = reg_wdata;
                GNPA_ADDR_TXNP: begin
                    st_next.tx_page_intermediate = reg_wdata;
                    st_next.sw_loaded            = 1'b1;
                end
                GNPA_ADDR_GIGCTL: st_next.local_gigabit_ability_word = reg_wdata;  // [RL6]
                GNPA_ADDR_CTRL: st_next.sw_mode = reg_wdata[GNPA_BIT_SWMODE];
                default: begin
                end
            endcase
        end

        // Register reads, data valid in the following cycle only
        if (reg_rd) begin
            case (reg_addr)
                GNPA_ADDR_BASE:   st_next.rdata = st_reg.base_page_intermediate;
                GNPA_ADDR_TXNP:   st_next.rdata = st_reg.tx_page_intermediate;
                GNPA_ADDR_RXNP:   st_next.rdata = st_reg.rx_page_word;
                GNPA_ADDR_GIGCTL: st_next.rdata = st_reg.local_gigabit_ability_word;  // [RL6]
                GNPA_ADDR_GIGST:  st_next.rdata = st_reg.partner_gigabit_ability_word;
                GNPA_ADDR_CTRL:   st_next.rdata = {15'h0000, st_reg.sw_mode};
                GNPA_ADDR_STAT:   st_next.rdata = {7'h00, st_reg.sw_loaded, res_count,
                                                   st_reg.tx_state, st_reg.rx_idx};
                default:          st_next.rdata = GNPA_RST_ZERO;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_reg                            <= '0;
            st_reg.base_page_intermediate     <= GNPA_RST_BASE;
            st_reg.local_gigabit_ability_word <= GNPA_RST_GIGCTL;
            st_reg.tx_state                   <= GNPA_TX_BASE;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // Resolution, run once on entry to link-good-check
    gnpa_resolve u_resolve (
        .sys_clk      (sys_clk),
        .rst          (rst),
        .ce           (ce),
        .resolve      (eng_good_check && !st_reg.good_check_d && gig_now),  // [RL21]
        .local_cfg    (st_reg.local_gigabit_ability_word[GNPA_BIT_MEN:GNPA_BIT_HD]),
        .local_seed   (local_seed),
        .partner_cfg  (st_reg.partner_gigabit_ability_word[GNPA_BIT_MEN:GNPA_BIT_HD]),
        .partner_seed (st_reg.partner_seed),                        // [RL9]
        .master       (res_master),
        .fault        (res_fault),
        .count        (res_count)
    );

    assign reg_rdata                 = st_reg.rdata;
    assign advertised_ability_word   = st_reg.adv_out;
    assign page_to_transmit          = st_reg.np_out;
    assign page_loaded_to_engine     = st_reg.np_loaded;
    assign gigabit_advert_wanted     = st_reg.gig_wanted;
    assign role_master               = st_reg.master_out;
    assign role_fault                = st_reg.fault_out;            // [RL4]
    assign failed_resolution_counter = st_reg.cnt_out;

    // ==========================================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence msg_taken_s;
        ce && !eng_restart && st_reg.tx_state == GNPA_TX_MSG && eng_tx_ack && st_reg.np_loaded;
    endsequence
    sequence up1_taken_s;
        ce && !eng_restart && st_reg.tx_state == GNPA_TX_UP1 && eng_tx_ack && st_reg.np_loaded;
    endsequence

    gig_order_a: assert property (msg_taken_s |=> st_reg.tx_state == GNPA_TX_UP1)  // [RL1]
        else $error("message page not followed by first unformatted page");
    up1_order_a: assert property (up1_taken_s |=> st_reg.tx_state == GNPA_TX_UP2)  // [RL1]
        else $error("first unformatted page not followed by second");
    soft_after_gig_a: assert property (                                           // [RL1]
        st_reg.tx_state == GNPA_TX_SOFT && $past(st_reg.tx_state) != GNPA_TX_SOFT
        && $past(gig_now) |-> $past(st_reg.tx_state) == GNPA_TX_UP2)
        else $error("user page sent before gigabit pages");
    advert_flag_a: assert property (ce ##1 1 |-> gigabit_advert_wanted ==         // [RL5]
        $past(gig_now))
        else $error("gigabit advert flag mismatch");
    rx_store_a: assert property (ce && eng_rx_valid && !reg_wr                    // [RL8]
        |=> st_reg.rx_page_word == $past(eng_rx_page))
        else $error("received page not stored");
    seed_store_a: assert property (ce && eng_rx_valid && gig_now                  // [RL9]
        && st_reg.rx_idx == GNPA_RX_UP2 |=> st_reg.partner_seed == $past(eng_rx_page[10:0]))
        else $error("partner seed not stored");
    auto_loaded_a: assert property (ce && !st_reg.sw_mode && !eng_restart         // [RL13]
        && st_reg.tx_state == GNPA_TX_MSG |=> page_loaded_to_engine)
        else $error("gigabit page not offered automatically");
    loaded_clear_a: assert property (ce && st_reg.tx_state == GNPA_TX_SOFT        // [RL16]
        && eng_tx_ack && st_reg.np_loaded && !reg_wr |=> !st_reg.sw_loaded)
        else $error("page loaded flag not cleared when taken");
    gigctl_read_a: assert property (ce && reg_rd && !reg_wr                       // [RL6]
        && reg_addr == GNPA_ADDR_GIGCTL |=> reg_rdata == $past(st_reg.local_gigabit_ability_word))
        else $error("register 9 read mismatch");

endmodule

// File: verification/gnpa_engine_model.sv
// Behavioural arbitration engine facing the add-on.
// Assumes its tasks are entered just after a rising sys_clk edge.
`timescale 1ns/1ps
module gnpa_engine_model (
    // Clock
    input  wire logic        sys_clk,
    // From the add-on
    input  wire logic [15:0] page_to_transmit,
    input  wire logic        page_loaded_to_engine,
    // To the add-on
    output logic             eng_restart,
    output logic             eng_tx_ack,
    output logic             eng_rx_valid,
    output logic      [15:0] eng_rx_page
);
    logic [15:0] sent[$];
    int          misses;
    initial begin
        eng_restart  = 1'b0;
        eng_tx_ack   = 1'b0;
        eng_rx_valid = 1'b0;
        eng_rx_page  = 16'h0000;
        misses       = 0;
    end
    // ==========================================
    // Page handshake
    task automatic pulse_ack();
        eng_tx_ack <= 1'b1;
        @(posedge sys_clk);
        eng_tx_ack <= 1'b0;
    endtask
    task automatic start();
        eng_restart <= 1'b1;
        @(posedge sys_clk);
        eng_restart <= 1'b0;
        repeat (2) @(posedge sys_clk);
        pulse_ack();
    endtask
    // Waits up to 40 cycles for a loaded page, then takes it anyway; gap models a slow engine
    task automatic take_pages(input int n, input int gap);
        int t;
        for (int i = 0; i < n; i++) begin
            t = 0;
            while (page_loaded_to_engine !== 1'b1 && t < 40) begin
                @(posedge sys_clk);
                t++;
            end
            if (t == 40) misses++;
            sent.push_back(page_to_transmit);
            repeat (gap) @(posedge sys_clk);
            pulse_ack();
            repeat (2) @(posedge sys_clk);
        end
    endtask
    // Released page bus shows the inverse so a stale value cannot pass
    task automatic send_rx(input logic [15:0] w);
        eng_rx_valid <= 1'b1;
        eng_rx_page  <= w;
        @(posedge sys_clk);
        eng_rx_valid <= 1'b0;
        eng_rx_page  <= ~w;
        @(posedge sys_clk);
    endtask
endmodule

// File: verification/test_gnpa_top.sv
// Self-checking bench for the gigabit next page add-on.
// Assumes the engine model drives the engine side; the bench owns registers.
`timescale 1ns/1ps
module test_gnpa_top;
    import gnpa_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic [4:0]  reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        eng_good_check = 1'b0;
    logic [10:0] local_seed = 11'h155;
    logic        eng_restart, eng_tx_ack, eng_rx_valid, loaded, wanted, master, fault;
    logic [15:0] eng_rx_page, reg_rdata, adv_word, tx_word;
    logic [2:0]  fail_cnt;
    int          err_count = 0;
    int          checked = 0;
    logic [15:0] ctl[4] = '{16'h0000, 16'h0100, 16'h0200, 16'h0300};
    logic [15:0] auto_pg[3] = '{16'hA008, 16'h8003, 16'h0155};
    logic [15:0] rx_pg[4] = '{16'hA008, 16'h8003, 16'h0155, 16'h2ABC};
    logic [15:0] sw_pg[5] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h8456, 16'h2001};
    logic [15:0] sw_exp[5] = '{16'hA008, 16'h8003, 16'h82AA, 16'h8456, 16'h2001};
    always #12.5 sys_clk = ~sys_clk;
    gnpa_top dut (.sys_clk(sys_clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .eng_restart(eng_restart), .eng_tx_ack(eng_tx_ack), .eng_rx_valid(eng_rx_valid),
        .eng_rx_page(eng_rx_page), .eng_good_check(eng_good_check),
        .local_seed(local_seed), .advertised_ability_word(adv_word),
        .page_to_transmit(tx_word), .page_loaded_to_engine(loaded),
        .gigabit_advert_wanted(wanted), .role_master(master), .role_fault(fault),
        .failed_resolution_counter(fail_cnt));
    gnpa_engine_model eng (.sys_clk(sys_clk), .page_to_transmit(tx_word),
        .page_loaded_to_engine(loaded), .eng_restart(eng_restart),
        .eng_tx_ack(eng_tx_ack), .eng_rx_valid(eng_rx_valid), .eng_rx_page(eng_rx_page));
    // ==========================================
    // Bus and check tasks
    task automatic complete_run();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [4:0] a, input logic [15:0] exp, input string what);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        @(posedge sys_clk);
        chk(what, exp, reg_rdata);
    endtask
    task automatic pages(input int n, input int gap);
        eng.take_pages(n, gap);
        if (eng.misses != 0) begin
            err_count++;
            $display("CHECK FAILED page wait expected loaded seen idle");
            complete_run();
        end
    endtask
    task automatic resolve();
        eng_good_check <= 1'b1;
        repeat (4) @(posedge sys_clk);
        eng_good_check <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask
    // ==========================================
    // Scenarios
    initial begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rd(GNPA_ADDR_BASE, GNPA_RST_BASE, "base reg");
        rd(GNPA_ADDR_GIGST, 16'h0000, "partner word");
        rd(5'h1F, 16'h0000, "unmapped");
        foreach (ctl[i]) begin
            wr(GNPA_ADDR_GIGCTL, ctl[i]);
            repeat (2) @(posedge sys_clk);
            chk("wanted", {15'h0000, ctl[i][8] | ctl[i][9]}, {15'h0000, wanted});
            rd(GNPA_ADDR_GIGCTL, ctl[i], "gig ctl");
        end
        eng.start();
        chk("base word", GNPA_RST_BASE | 16'h8000, adv_word);
        pages(3, 0);
        chk("loaded", 16'h0000, {15'h0000, loaded});
        foreach (auto_pg[i]) chk("auto page", auto_pg[i], eng.sent.pop_front());
        foreach (rx_pg[i]) begin
            eng.send_rx(rx_pg[i]);
            rd(GNPA_ADDR_RXNP, rx_pg[i], "rx page");
        end
        rd(GNPA_ADDR_GIGST, 16'h0300, "partner word");
        wr(GNPA_ADDR_RXNP, 16'hFFFF);
        rd(GNPA_ADDR_RXNP, 16'h2ABC, "read-only rx");
        rd(GNPA_ADDR_STAT, 16'h0017, "status");
        // Equal seeds force failed resolutions past the counter ceiling
        for (int k = 1; k <= 8; k++) begin
            resolve();
            chk("fail count", k > 7 ? 16'h0007 : 16'(k), {13'h0000, fail_cnt});
            chk("fault", {15'h0000, k >= 7}, {15'h0000, fault});
        end
        local_seed <= 11'h2AA;
        resolve();
        chk("fail count", 16'h0000, {13'h0000, fail_cnt});
        chk("master", 16'h0001, {15'h0000, master});
        rd(GNPA_ADDR_GIGST, 16'h4300, "partner word");
        wr(GNPA_ADDR_CTRL, 16'h0001);
        eng.start();
        // Software ignores the first three received pages; the partner asks for manual master
        foreach (rx_pg[i]) eng.send_rx(rx_pg[i] ^ 16'h001B);
        rd(GNPA_ADDR_RXNP, 16'h2AA7, "sw rx page");
        rd(GNPA_ADDR_GIGST, 16'h5800, "sw partner word");
        foreach (sw_pg[i]) begin
            wr(GNPA_ADDR_TXNP, sw_pg[i]);
            pages(1, 3);
            chk("sw page", sw_exp[i], eng.sent.pop_front());
        end
        chk("loaded", 16'h0000, {15'h0000, loaded});
        // Both sides manual with the same value must report a role fault
        wr(GNPA_ADDR_GIGCTL, 16'h1B00);
        resolve();
        chk("manual fault", 16'h0001, {15'h0000, fault});
        rd(GNPA_ADDR_STAT, 16'h0017, "status");
        complete_run();
    end
endmodule
